// >>> core/sap_serial_ports.sv
// Serial audio input and output ports on twelve multipurpose pins, Wishbone register access
// Operation
// [RQ1] Pins 0-5 input port, 6-11 output port
// [RQ2] Input clocks slave; output clocks master or slave
// [RQ3] Input and output formats set independently
// [RQ4] Slave ADC needs master output clocks looped back
// [RQ5] Slave ADC returns data on an input line
// [RQ6] DAC served only by the output port
// [RQ7] Data changes on falling bit clock
// [RQ8] I2S: falling frame edge, MSB one bit late
// [RQ9] Left-justified: rising frame edge, MSB aligned
// [RQ10] Right-justified: MSB delayed 8, 12 or 16
// [RQ11] TDM clock: falling edge, MSB one bit late
// [RQ12] TDM pulse: rising pulse, MSB one bit late
// [RQ13] TDM uses data line zero both ways
// [RQ14] Right-justified needs exactly 64 bit clocks
// [RQ15] TDM at 192 kHz: output port slave only
// [RQ16] Words truncated to 24 bits, no error
// [RQ17] TDM frame: eight 32-bit slots, MSB first
`timescale 1ns/10ps
`include "sap_consts.svh"
module sap_serial_ports #(
  parameter int BCLK_DIV = `SAP_BCLK_DIV
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Multipurpose pins
  input wire logic [11:0] multipurpose_pins_i,
  output logic [11:0] multipurpose_pins_o,
  output logic [11:0] multipurpose_pins_oe_n_o
);
  import sap_pkg::*;

  sap_state_t st_ff;
  sap_state_t nxt_st;

  // MSB delay from the frame marker in bit clocks
  function automatic logic [8:0] msb_dly(input logic [2:0] fmt, input logic [1:0] rjd);
    if (fmt == SAP_FMT_LJ) begin
      return 9'h000;
    end else if (fmt == SAP_FMT_RJ) begin
      return (rjd == 2'h0) ? `SAP_DLY_RJ8 : (rjd == 2'h1) ? `SAP_DLY_RJ12 : `SAP_DLY_RJ16;
    end
    return `SAP_DLY_ONE;
  endfunction

  function automatic logic is_tdm(input logic [2:0] fmt);
    return fmt == SAP_FMT_TDMC || fmt == SAP_FMT_TDMP;
  endfunction

  // Marker edge: any edge in two-channel modes, one edge in TDM
  function automatic logic mark_edge(input logic [2:0] fmt, input logic lr, input logic lr_q);
    logic e;
    e = lr != lr_q;
    if (fmt == SAP_FMT_TDMC) begin
      return e && !lr;
    end else if (fmt == SAP_FMT_TDMP) begin
      return e && lr;
    end
    return e;
  endfunction

  // Bit info for a position: {valid, last, slot[2:0], index[4:0]}
  function automatic logic [9:0] bit_info(input logic [2:0] fmt, input logic [1:0] rjd,
                                          input logic [8:0] pos, input logic lr);
    logic [8:0] p;
    logic [7:0] w;
    logic [4:0] wl;
    logic v;
    logic [2:0] sl;
    p = pos - msb_dly(fmt, rjd);
    w = is_tdm(fmt) ? {3'h0, p[4:0]} : p[7:0];
    wl = (fmt == SAP_FMT_RJ) ? 5'(6'h20 - 6'(msb_dly(fmt, rjd))) : `SAP_WLEN;
    v = !p[8] && (w < {3'h0, wl});
    sl = is_tdm(fmt) ? p[7:5] : {2'h0, (fmt == SAP_FMT_I2S) ? lr : !lr};
    return {v, v && (w[4:0] == 5'(wl - 5'h01)), sl, w[4:0]};
  endfunction

  logic [2:0] ifmt, ofmt;
  logic [1:0] rjd;
  logic en, irise, ofall, orise, ob_src, ol_src, acc, rx_pop, tx_push;
  logic [1:0] widx;
  logic [8:0] q, flen, idly;
  logic [9:0] bi, bo;
  logic [23:0] w, tw;
  logic dline, tbit;

  // Field decode and edge detection on synchronised pins, or on the master clocks when the master is active
  assign ifmt = st_ff.ctrl[`SAP_C_IFMT +: 3]; // RQ3
  assign ofmt = st_ff.ctrl[`SAP_C_OFMT +: 3]; // RQ3
  assign rjd = st_ff.ctrl[`SAP_C_RJD +: 2];
  assign en = st_ff.ctrl[`SAP_C_EN];
  assign irise = en && st_ff.s2[5] && !st_ff.ibp;
  // Master output clocks feed the output engine directly, no sync needed
  assign ob_src = st_ff.mact ? st_ff.mbclk : st_ff.s2[7];
  assign ol_src = st_ff.mact ? st_ff.mlr : st_ff.s2[6];
  assign orise = en && ob_src && !st_ff.obp;
  assign ofall = en && !ob_src && st_ff.obp; // RQ7
  assign acc = wb_cyc_i && wb_stb_i && !st_ff.ack;
  assign widx = wb_adr_i[3:2];
  assign tx_push = acc && wb_we_i && widx == `SAP_IDX_TXD && st_ff.bcnt != 2'h2;
  assign rx_pop = acc && !wb_we_i && widx == `SAP_IDX_RXD;
  assign flen = is_tdm(ofmt) ? `SAP_FRAME_TDM : `SAP_FRAME_2CH; // RQ14 RQ17
  assign idly = msb_dly(ifmt, rjd);

  // Next state of the whole block
  always_comb begin
    nxt_st = st_ff;
    bi = 10'h000;
    bo = 10'h000;
    w = st_ff.iword;
    tw = st_ff.oword;
    q = 9'h000;
    tbit = 1'b0;
    // Two-flop synchronisers for input port pins and output clock pins
    nxt_st.s1 = {multipurpose_pins_i[11:10], multipurpose_pins_i[5:0]};
    nxt_st.s2 = st_ff.s1;
    nxt_st.ibp = st_ff.s2[5];
    nxt_st.obp = ob_src;
    // Data line select; in two-channel formats a slave ADC may use any of the four lines
    dline = is_tdm(ifmt) ? st_ff.s2[0] : st_ff.s2[st_ff.ctrl[`SAP_C_ILINE +: 2]]; // RQ5 RQ13
    // Input engine samples on the rising bit clock
    if (irise) begin
      nxt_st.il_q = st_ff.s2[4];
      nxt_st.ipos = mark_edge(ifmt, st_ff.s2[4], st_ff.il_q) ? 9'h000 : 9'(st_ff.ipos + 9'h001); // RQ8 RQ9 RQ11 RQ12
      bi = bit_info(ifmt, rjd, nxt_st.ipos, st_ff.s2[4]); // RQ10
      if (bi[9]) begin
        if (bi[4:0] == 5'h00) begin
          w = 24'h000000;
        end
        w[5'h17 - bi[4:0]] = dline; // RQ16
        nxt_st.iword = w;
      end
      // Completed word; unread previous word counts as overrun
      if (bi[8]) begin
        nxt_st.rx_word = w;
        nxt_st.rx_slot = bi[7:5];
      end
    end
    // Output engine: learn marker spacing at rise, drive at fall
    if (orise) begin
      nxt_st.ol_q = ol_src;
      if (mark_edge(ofmt, ol_src, st_ff.ol_q)) begin
        nxt_st.opos = 9'h000;
        nxt_st.olen = 9'(st_ff.opos + 9'h001);
      end else begin
        nxt_st.opos = 9'(st_ff.opos + 9'h001);
      end
    end
    // Predict next position so data leads the rising edge
    if (ofall) begin
      q = (9'(st_ff.opos + 9'h001) == st_ff.olen) ? 9'h000 : 9'(st_ff.opos + 9'h001);
      bo = bit_info(ofmt, rjd, q, st_ff.ol_q);
      if (bo[9] && bo[4:0] == 5'h00) begin
        if (st_ff.bcnt != 2'h0) begin
          tw = st_ff.buf0;
          nxt_st.buf0 = st_ff.buf1;
          nxt_st.bcnt = 2'(st_ff.bcnt - 2'h1);
        end else begin
          tw = 24'h000000;
          nxt_st.udr = 1'b1;
        end
        nxt_st.oword = tw;
      end
      tbit = bo[9] && tw[5'h17 - bo[4:0]]; // RQ17
      nxt_st.olines = 4'h0;
      if (is_tdm(ofmt)) begin
        nxt_st.olines[0] = tbit; // RQ13
      end else begin
        nxt_st.olines[st_ff.ctrl[`SAP_C_OLINE +: 2]] = tbit; // RQ6
      end
    end
    // Transmit buffer push; the write stalls while both entries hold words
    if (tx_push) begin
      if (nxt_st.bcnt == 2'h0) begin
        nxt_st.buf0 = wb_dat_i[23:0];
      end else begin
        nxt_st.buf1 = wb_dat_i[23:0];
      end
      nxt_st.bcnt = 2'(nxt_st.bcnt + 2'h1);
    end
    // Receive holding flag: a new word wins over a pop in the same cycle
    if (irise && bi[8]) begin
      nxt_st.rx_valid = 1'b1;
      if (st_ff.rx_valid && !rx_pop) begin
        nxt_st.ovr = 1'b1;
      end
    end else if (rx_pop) begin
      nxt_st.rx_valid = 1'b0;
    end
    // Master clock generator; TDM at 192 kHz refuses master
    nxt_st.mact = en && st_ff.ctrl[`SAP_C_MST] && !(is_tdm(ofmt) && st_ff.ctrl[`SAP_C_R192]); // RQ2 RQ15
    if (!st_ff.mact) begin
      nxt_st.mdiv = 8'h00;
      nxt_st.mbclk = 1'b1;
      nxt_st.mpos = 9'(flen - 9'h001);
      nxt_st.mlr = 1'b0;
    end else if (st_ff.mdiv == 8'(BCLK_DIV - 1)) begin
      nxt_st.mdiv = 8'h00;
      nxt_st.mbclk = !st_ff.mbclk;
      // Frame clock moves on the falling bit clock
      if (st_ff.mbclk) begin
        nxt_st.mpos = (9'(st_ff.mpos + 9'h001) >= flen) ? 9'h000 : 9'(st_ff.mpos + 9'h001);
        unique case (ofmt)
          SAP_FMT_I2S: nxt_st.mlr = nxt_st.mpos >= `SAP_HALF_2CH; // RQ8
          SAP_FMT_TDMC: nxt_st.mlr = nxt_st.mpos >= `SAP_HALF_TDM; // RQ11
          SAP_FMT_TDMP: nxt_st.mlr = nxt_st.mpos == 9'h000; // RQ12
          default: nxt_st.mlr = nxt_st.mpos < `SAP_HALF_2CH; // RQ9 RQ10
        endcase
      end
    end else begin
      nxt_st.mdiv = 8'(st_ff.mdiv + 8'h01);
    end
    // Bus access; writes take effect in the cycle that raises ack
    nxt_st.ack = acc && !(wb_we_i && widx == `SAP_IDX_TXD && st_ff.bcnt == 2'h2);
    if (nxt_st.ack && wb_we_i && widx == `SAP_IDX_CTRL) begin
      if (wb_sel_i[0]) begin
        nxt_st.ctrl[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        nxt_st.ctrl[15:8] = wb_dat_i[15:8];
      end
    end
    // Write one clears sticky flags, unless set again this cycle
    if (nxt_st.ack && wb_we_i && widx == `SAP_IDX_STAT && wb_sel_i[0]) begin
      if (wb_dat_i[`SAP_S_OVR] && !(irise && bi[8] && st_ff.rx_valid && !rx_pop)) begin
        nxt_st.ovr = 1'b0;
      end
      if (wb_dat_i[`SAP_S_UDR] && !(ofall && bo[9] && bo[4:0] == 5'h00 && st_ff.bcnt == 2'h0)) begin
        nxt_st.udr = 1'b0;
      end
    end
    unique case (widx)
      `SAP_IDX_CTRL: nxt_st.rdat = {16'h0000, st_ff.ctrl};
      `SAP_IDX_STAT: nxt_st.rdat = {24'h000000, st_ff.rx_slot, st_ff.udr, st_ff.mact,
                                    st_ff.bcnt == 2'h2, st_ff.ovr, st_ff.rx_valid};
      `SAP_IDX_RXD: nxt_st.rdat = {5'h00, st_ff.rx_slot, st_ff.rx_word};
      default: nxt_st.rdat = 32'h00000000;
    endcase
    if (rst_i) begin
      nxt_st = '0;
      nxt_st.ctrl = `SAP_CTRL_RST;
      nxt_st.mbclk = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    st_ff <= nxt_st;
  end

  // Pin drive; input port pins are never driven, enable low means driving
  assign multipurpose_pins_o = {st_ff.mbclk & st_ff.mact, st_ff.mlr & st_ff.mact, st_ff.olines, 6'h00}; // RQ1
  assign multipurpose_pins_oe_n_o = {{2{!st_ff.mact}}, {4{!en}}, 6'h3F}; // RQ1 RQ2 RQ4
  assign wb_dat_o = st_ff.ack ? st_ff.rdat : 32'h00000000;
  assign wb_ack_o = st_ff.ack;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  in_pins_idle_a: assert property (multipurpose_pins_oe_n_o[5:0] == 6'h3F) // RQ1
    else $error("input port pin driven");
  out_clk_dir_a: assert property (!multipurpose_pins_oe_n_o[11] |-> st_ff.mact) // RQ2
    else $error("output bit clock driven in slave mode");
  tdm192_slave_a: assert property (en && is_tdm(ofmt) && st_ff.ctrl[`SAP_C_R192] |=> !st_ff.mact) // RQ15
    else $error("master active for TDM at 192 kHz");
  data_on_fall_a: assert property ($changed(st_ff.olines) |-> $past(ofall)) // RQ7
    else $error("output data changed away from falling bit clock");
  tdm_line0_a: assert property (ofall && is_tdm(ofmt) |=> st_ff.olines[3:1] == 3'h0) // RQ13
    else $error("TDM output on a line other than zero");
  i2s_commit_a: assert property ($rose(st_ff.rx_valid) && ifmt == SAP_FMT_I2S |-> st_ff.ipos == 9'h018) // RQ8
    else $error("I2S word not ended one bit after 24 data bits");
  lj_commit_a: assert property ($rose(st_ff.rx_valid) && ifmt == SAP_FMT_LJ |-> st_ff.ipos == 9'h017) // RQ9
    else $error("left-justified word not ended at bit 23");
  rj_commit_a: assert property ($rose(st_ff.rx_valid) && ifmt == SAP_FMT_RJ |-> st_ff.ipos == 9'h01F) // RQ10
    else $error("right-justified word not ended at bit 31");
  tdm_commit_a: assert property ($rose(st_ff.rx_valid) && is_tdm(ifmt) |-> st_ff.ipos[4:0] == 5'h18) // RQ11 RQ12
    else $error("TDM slot word misplaced");
  word_width_a: assert property ($rose(st_ff.rx_valid) && ifmt != SAP_FMT_RJ |-> st_ff.ipos == 9'(idly + 9'h017)
                                 || is_tdm(ifmt)) // RQ16
    else $error("word longer than 24 bits accepted");
  tx_stall_a: assert property (wb_cyc_i && wb_stb_i && wb_we_i && widx == `SAP_IDX_TXD && st_ff.bcnt == 2'h2
                               && !st_ff.ack |=> !st_ff.ack) // RQ6
    else $error("write accepted into a full transmit buffer");
  frame_len_a: assert property (st_ff.mact |-> st_ff.mpos < flen) // RQ17
    else $error("master frame position beyond frame length");

  rx_tdm_c: cover property ($rose(st_ff.rx_valid) && is_tdm(ifmt) && st_ff.rx_slot == 3'h7);
  tx_udr_c: cover property ($rose(st_ff.udr));
  master_run_c: cover property (st_ff.mact && $rose(st_ff.mlr));
  buf_full_c: cover property (st_ff.bcnt == 2'h2 ##1 st_ff.bcnt == 2'h1);
endmodule

// >>> core/sap_consts.svh
// Register map, field positions, reset values and timing counts of the serial audio ports
`ifndef SAP_CONSTS_SVH
`define SAP_CONSTS_SVH
// Word indices; byte address is four times the index
`define SAP_IDX_CTRL 2'h0
`define SAP_IDX_STAT 2'h1
`define SAP_IDX_RXD 2'h2
`define SAP_IDX_TXD 2'h3
// Control field positions
`define SAP_C_IFMT 0
`define SAP_C_OFMT 3
`define SAP_C_MST 6
`define SAP_C_RJD 7
`define SAP_C_ILINE 9
`define SAP_C_OLINE 11
`define SAP_C_R192 13
`define SAP_C_EN 14
`define SAP_CTRL_RST 16'h0000
// Status bit positions
`define SAP_S_RXV 0
`define SAP_S_OVR 1
`define SAP_S_FULL 2
`define SAP_S_MACT 3
`define SAP_S_UDR 4
`define SAP_S_SLOT 5
// Framing counts in bit clocks
`define SAP_DLY_ONE 9'h001
`define SAP_DLY_RJ8 9'h008
`define SAP_DLY_RJ12 9'h00C
`define SAP_DLY_RJ16 9'h010
`define SAP_WLEN 5'h18
`define SAP_HALF_2CH 9'h020
`define SAP_FRAME_2CH 9'h040
`define SAP_HALF_TDM 9'h080
`define SAP_FRAME_TDM 9'h100
// Master bit clock half period in system clocks
`define SAP_BCLK_DIV 4
`endif

// >>> core/sap_pkg.sv
// Types shared by the serial audio ports
package sap_pkg;
  typedef enum logic [2:0] {
    SAP_FMT_I2S = 3'h0,
    SAP_FMT_LJ = 3'h1,
    SAP_FMT_RJ = 3'h2,
    SAP_FMT_TDMC = 3'h3,
    SAP_FMT_TDMP = 3'h4
  } sap_fmt_t;

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic ibp;
    logic il_q;
    logic [8:0] ipos;
    logic [23:0] iword;
    logic [23:0] rx_word;
    logic [2:0] rx_slot;
    logic rx_valid;
    logic ovr;
    logic obp;
    logic ol_q;
    logic [8:0] opos;
    logic [8:0] olen;
    logic [23:0] oword;
    logic [3:0] olines;
    logic udr;
    logic [15:0] ctrl;
    logic [23:0] buf0;
    logic [23:0] buf1;
    logic [1:0] bcnt;
    logic ack;
    logic [31:0] rdat;
    logic [7:0] mdiv;
    logic mbclk;
    logic mlr;
    logic [8:0] mpos;
    logic mact;
  } sap_state_t;
endpackage

// >>> verif/sap_audio_partner.sv
// Far-side audio source on the input pins and sink on the output pins
`timescale 1ns/10ps
module sap_audio_partner (
  // Input port pins: data 3:0, frame clock 4, bit clock 5
  output logic [5:0] in_pins_o,
  // Resolved level of all twelve pins
  input wire logic [11:0] pins_i
);
  // Bit clock stands low and data rests at the pull-up level
  initial in_pins_o = 6'h1F;

  // One frame; a lead-in bit at the end level makes the opening edge visible
  task automatic send_frame(input int fmt, input int d, input int ln, input logic [23:0] w [8]);
    int n;
    int p;
    int k;
    logic b;
    n = (fmt >= 3) ? 256 : 64;
    for (int q = -1; q < n; q++) begin
      p = (q < 0) ? n - 1 : q;
      k = p % 32 - d;
      b = (q >= 0 && k >= 0 && k < 24) ? w[p / 32][23 - k] : 1'h1;
      in_pins_o[5] = 1'h0;
      case (fmt)
        0, 3: in_pins_o[4] = (p >= n / 2);
        4: in_pins_o[4] = (p == 0);
        default: in_pins_o[4] = (p < n / 2);
      endcase
      // Unused lines carry the inverse, so a wrong line select shows
      in_pins_o[3:0] = {4{~b}};
      in_pins_o[ln] = b;
      #100;
      in_pins_o[5] = 1'h1;
      #100;
    end
    in_pins_o[5] = 1'h0;
    in_pins_o[3:0] = 4'hF;
  endtask

  // Collects one I2S frame from an output line on bit clock rises
  task automatic grab_i2s(input int ln, output logic [23:0] l, output logic [23:0] r);
    logic lr_q;
    logic st;
    // Start from the pin's present level so no false frame edge is seen
    lr_q = pins_i[10];
    do begin
      @(posedge pins_i[11]);
      st = lr_q & ~pins_i[10];
      lr_q = pins_i[10];
    end while (!st);
    for (int i = 1; i < 64; i++) begin
      @(posedge pins_i[11]);
      if (i <= 24) l[24 - i] = pins_i[6 + ln];
      if (i >= 33 && i <= 56) r[56 - i] = pins_i[6 + ln];
    end
  endtask
endmodule

// >>> verif/testbench.sv
// Self-checking bench: registers, input framing in every format, master output
`timescale 1ns/10ps
module testbench;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic wb_cyc_i = 1'h0;
  logic wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [5:0] in_pins;
  logic [11:0] pins_o;
  logic [11:0] oe_n;
  logic [11:0] pins;
  int num_errors = 0;
  int tests_run = 0;
  int exq[$];
  int fm [7] = '{0, 1, 2, 2, 2, 3, 4};
  int dl [7] = '{1, 0, 8, 12, 16, 1, 1};

  // Undriven output pins rest at the pull-up level
  assign pins = {(pins_o[11:6] & ~oe_n[11:6]) | oe_n[11:6], in_pins};

  // 40 MHz system clock
  always #12.5 clk_i = ~clk_i;

  sap_serial_ports i_sap_serial_ports (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .multipurpose_pins_i(pins),
    .multipurpose_pins_o(pins_o),
    .multipurpose_pins_oe_n_o(oe_n)
  );

  sap_audio_partner i_sap_audio_partner (
    .in_pins_o(in_pins),
    .pins_i(pins)
  );

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Classic cycle; the request is held until ack is seen high at a rising edge
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] v, output logic [31:0] q);
    int t;
    t = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= v;
    // Ack and read data are taken at the rising edge that samples ack high
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack_o !== 1'h1 && t < 400);
    q = wb_dat_o;
    if (t >= 400) num_errors++;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    logic [31:0] x;
    wb(1'h1, a, v, x);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] q);
    wb(1'h0, a, 32'h0, q);
  endtask

  // Polls for a received word, then pops it
  task automatic poll_rx(output logic [31:0] q);
    int t;
    t = 0;
    do begin
      rd(4'h4, q);
      t++;
    end while (q[0] !== 1'h1 && t < 2000);
    rd(4'h8, q);
  endtask

  // Main sequence
  initial begin
    logic [31:0] d;
    logic [23:0] w [8];
    logic [23:0] mk;
    logic [23:0] gl;
    logic [23:0] gr;
    logic [1:0] ln;
    logic [1:0] rs;
    void'($urandom(67));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'h0;
    check("pin enables", 32'hFFF, {20'h0, oe_n});
    rd(4'h0, d);
    check("ctrl reset", 32'h0, d);
    rd(4'h4, d);
    check("status reset", 32'h0, d);
    // Every input format; output format set apart to show independence
    for (int m = 0; m < 7; m++) begin
      ln = (fm[m] >= 3) ? 2'h0 : 2'($urandom_range(3));
      rs = 2'((dl[m] - 8) / 4);
      mk = (fm[m] == 2) ? 24'hFFFFFF << (dl[m] - 8) : 24'hFFFFFF;
      wr(4'h0, {17'h0, 4'h8, ln, rs, 4'h1, 3'(fm[m])});
      for (int s = 0; s < 8; s++) begin
        w[s] = 24'($urandom);
        if (fm[m] >= 3 || s < 2) exq.push_back({s[2:0], w[s] & mk});
      end
      fork
        i_sap_audio_partner.send_frame(fm[m], dl[m], ln, w);
        repeat (exq.size()) begin
          poll_rx(d);
          check("rx word", exq.pop_front(), {5'h0, d[26:0]});
        end
      join
    end
    // Start the master on an empty buffer; the first frame only teaches the marker spacing
    ln = 2'($urandom_range(3));
    wr(4'h0, {17'h0, 1'h1, 1'h0, ln, 4'h0, 7'h40});
    rd(4'h4, d);
    check("master active", 32'h1, {31'h0, d[3]});
    @(negedge clk_i);
    check("pin enables", 32'h03F, {20'h0, oe_n});
    repeat (140) @(posedge pins[11]);
    rd(4'h4, d);
    check("tx underrun", 32'h1, {31'h0, d[4]});
    // Queue the pair just after the right word was taken, so both land in the next frame
    @(posedge pins[10]);
    repeat (4) @(posedge pins[11]);
    gl = 24'($urandom) | 24'h1;
    gr = 24'($urandom);
    wr(4'hC, {8'h0, gl});
    wr(4'hC, {8'h0, gr});
    rd(4'h4, d);
    check("tx full", 32'h1, {31'h0, d[2]});
    w[0] = 24'h0;
    for (int f = 0; f < 4 && w[0] !== gl; f++) begin
      i_sap_audio_partner.grab_i2s(ln, w[0], w[1]);
    end
    check("out left", {8'h0, gl}, {8'h0, w[0]});
    check("out right", {8'h0, gr}, {8'h0, w[1]});
    // TDM master at the high rate is refused; without the flag it runs
    wr(4'h0, {17'h0, 2'h3, ln, 4'h0, 7'h58});
    rd(4'h4, d);
    check("tdm high rate master", 32'h0, {31'h0, d[3]});
    @(negedge clk_i);
    check("tdm high rate clocks", 32'h3, {30'h0, oe_n[11:10]});
    wr(4'h0, {17'h0, 2'h2, ln, 4'h0, 7'h58});
    rd(4'h4, d);
    check("tdm master", 32'h1, {31'h0, d[3]});
    complete_run();
  end

  // Cuts a hung run short
  initial begin
    #2000000;
    num_errors++;
    complete_run();
  end
endmodule
